// [pkg/pulse_reference_decoder_defs.vh]
// constants for the reference pulse decoder
`ifndef PULSE_REFERENCE_DECODER_DEFS_VH
`define PULSE_REFERENCE_DECODER_DEFS_VH
// pulse configuration switch field positions
`define PCS_FORM_LSB 3
`define PCS_FORM_MSB 5
`define PCS_CLRMODE_BIT 10
`define PCS_LOGIC_BIT 13
`define PCS_RESET_VALUE 16'h0000
// pulse form codes
`define FORM_SIGN_PULSE 3'h0
`define FORM_FWD_REV 3'h1
`define FORM_QUAD_X1 3'h2
`define FORM_QUAD_X2 3'h3
`define FORM_QUAD_X4 3'h4
// timing: clock rate in kHz, least clear width in ns
`define SYS_CLK_KHZ 50000
`define CLR_MIN_NS 20000
`define CLR_MIN_CYCLES ((`CLR_MIN_NS * `SYS_CLK_KHZ + 999999) / 1000000)
// cycles after reset before decoded pin edges are trusted
`define SETTLE_CYCLES 2'h3
// error counter width
`define ERR_W 32
`define ERR_ZERO 32'h00000000
`endif

// [design/edge_sync.v]
// two-stage synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module edge_sync (
	input  wire sys_clk,  // system clock
	input  wire sys_rst,  // synchronous reset, active high
	input  wire async_in, // raw pin level
	output wire level,    // synchronised level
	output wire rise,     // one-cycle pulse on rising edge
	output wire fall      // one-cycle pulse on falling edge
);
	reg meta_r;
	reg sync_r;
	reg prev_r;

	// first stage is read only by the second
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise  = sync_r & ~prev_r;
	assign fall  = ~sync_r & prev_r;
endmodule // edge_sync

// [design/pulse_reference_decoder.v]
// reference pulse decoder driving the position error counter
// Overview of operation
// - sign plus pulse form is accepted at up to 450 kpps and the controller keeps below that.
// - in sign plus pulse form a high direction level means positive, a low one negative.
// - quadrature form is accepted up to 450, 400 and 200 kpps at x1, x2 and x4.
// - the quadrature multiplier comes from bits three to five of the configuration switch.
// - forward and reverse pulse trains are each accepted at up to 450 kpps.
// - an active clear input forces the error counter to zero.
// - while the clear input is high the position loop is disabled.
// - one configuration bit picks level or edge clearing, defaulting to level.
// - in level mode the counter stays cleared while clear is high.
// - in level mode no error pulses accumulate while clear is high.
// - in edge mode the counter clears once per rising edge of clear and counts afterwards.
// - form codes 000, 001, 010, 011 and 100 mean sign+pulse, fwd+rev, quad x1, x2 and x4.
// - a logic bit selects positive or negative logic, inverting the two pulse input levels; the clear input is not inverted.
`timescale 1ns/1ps
`include "pulse_reference_decoder_defs.vh"
module pulse_reference_decoder (
	input  wire                  sys_clk,             // system clock, 50 MHz
	input  wire                  sys_rst,             // synchronous reset, active high
	input  wire                  reference_pulse_in,  // pulse / phase A / forward pin
	input  wire                  reference_sign_in,   // sign / phase B / reverse pin
	input  wire                  counter_clear_in,    // error counter clear pin
	input  wire [15:0]           pulse_config_switch, // memory switch word
	input  wire                  feedback_up,         // one-cycle motor feedback count, plus
	input  wire                  feedback_down,       // one-cycle motor feedback count, minus
	output reg  [`ERR_W-1:0]     error_count,         // signed position error
	output reg                   position_loop_en,    // low while loop is prohibited
	output reg                   ref_step             // one-cycle pulse per counted step
);
	localparam CLR_CNT_W = 12;
	localparam [31:0] CLR_MIN_FULL = `CLR_MIN_CYCLES;
	localparam [CLR_CNT_W-1:0] CLR_MIN = CLR_MIN_FULL[CLR_CNT_W-1:0];

	// clear qualifier states
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_QUAL  = 3'b010;
	localparam [2:0] ST_VALID = 3'b100;

	wire       pa_lvl;
	wire       pa_rise;
	wire       pa_fall;
	wire       pb_lvl;
	wire       pb_rise;
	wire       pb_fall;
	wire       clr_lvl;
	wire       clr_rise_raw;
	wire [2:0] form;
	wire       clr_edge_mode;
	wire       neg_logic;
	wire       clr_raw;

	reg  [2:0]            cfg_form_r;
	reg                   cfg_clrmode_r;
	reg                   cfg_neg_r;
	reg  [2:0]            clr_st_r;
	reg  [2:0]            clr_st_nxt;
	reg  [CLR_CNT_W-1:0]  clr_cnt_r;
	reg  [CLR_CNT_W-1:0]  clr_cnt_nxt;
	reg                   clr_fire;
	reg  signed [3:0]     step;
	reg  signed [3:0]     fb;
	reg                   clr_active;

	// both pulse pins and the clear pin pass two flip-flops first
	edge_sync u_sync_a (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (reference_pulse_in),
		.level    (pa_lvl),
		.rise     (pa_rise),
		.fall     (pa_fall)
	);
	edge_sync u_sync_b (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (reference_sign_in),
		.level    (pb_lvl),
		.rise     (pb_rise),
		.fall     (pb_fall)
	);
	edge_sync u_sync_c (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (counter_clear_in),
		.level    (clr_lvl),
		.rise     (clr_rise_raw),
		.fall     ()
	);

	// switch word is a pin group from outside, so it is registered twice too
	reg [15:0] sw_meta_r;
	reg [15:0] sw_sync_r;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			sw_meta_r <= `PCS_RESET_VALUE;
			sw_sync_r <= `PCS_RESET_VALUE;
		end else begin
			sw_meta_r <= pulse_config_switch;
			sw_sync_r <= sw_meta_r;
		end
	end

	// field extraction
	assign form          = sw_sync_r[`PCS_FORM_MSB:`PCS_FORM_LSB];
	assign clr_edge_mode = sw_sync_r[`PCS_CLRMODE_BIT];
	assign neg_logic     = sw_sync_r[`PCS_LOGIC_BIT];

	// configuration held in registers so it only changes between decode cycles
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_form_r    <= `FORM_SIGN_PULSE;
			cfg_clrmode_r <= 1'b0;
			cfg_neg_r     <= 1'b0;
		end else begin
			cfg_form_r    <= form;
			cfg_clrmode_r <= clr_edge_mode;
			cfg_neg_r     <= neg_logic;
		end
	end

	// clear level straight from the synchroniser; the qualifier below drops pulses under the least width
	assign clr_raw = clr_lvl;

	// clear qualifier: high for CLR_MIN cycles before it counts as active
	always @* begin
		clr_st_nxt  = clr_st_r;
		clr_cnt_nxt = clr_cnt_r;
		clr_fire    = 1'b0;
		case (clr_st_r)
			ST_IDLE: begin
				clr_cnt_nxt = {CLR_CNT_W{1'b0}};
				if (clr_rise_raw) begin
					clr_st_nxt  = ST_QUAL;
					clr_cnt_nxt = {{(CLR_CNT_W-1){1'b0}}, 1'b1};
				end
			end
			ST_QUAL: begin
				if (!clr_raw) begin
					clr_st_nxt = ST_IDLE;
				end else if (clr_cnt_r >= CLR_MIN - 1'b1) begin
					clr_st_nxt = ST_VALID;
					clr_fire   = 1'b1;
				end else begin
					clr_cnt_nxt = clr_cnt_r + 1'b1;
				end
			end
			ST_VALID: begin
				if (!clr_raw) begin
					clr_st_nxt = ST_IDLE;
				end
			end
			default: begin
				clr_st_nxt  = ST_IDLE;
				clr_cnt_nxt = {CLR_CNT_W{1'b0}};
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			clr_st_r  <= ST_IDLE;
			clr_cnt_r <= {CLR_CNT_W{1'b0}};
		end else begin
			clr_st_r  <= clr_st_nxt;
			clr_cnt_r <= clr_cnt_nxt;
		end
	end

	// decode is held off after reset until every synchroniser stage and the
	// configuration registers carry real samples; without it a pin idling
	// high would look like a fresh rising edge under the reset configuration
	reg  [1:0]            settle_r;
	wire                  settle_done;
	assign settle_done = (settle_r == `SETTLE_CYCLES);
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			settle_r <= 2'h0;
		end else if (!settle_done) begin
			settle_r <= settle_r + 2'h1;
		end
	end

	// reference step decode; negative logic swaps level sense and edge polarity
	always @* begin
		step = 4'sd0;
		case (cfg_form_r)
			`FORM_SIGN_PULSE: begin
				// count on the active edge, sign level picks direction
				if (cfg_neg_r ? pa_fall : pa_rise) begin
					step = ((pb_lvl ^ cfg_neg_r) ? 4'sd1 : -4'sd1);
				end
			end
			`FORM_FWD_REV: begin
				// each train counts in its own direction; coincident edges cancel
				if (cfg_neg_r ? pa_fall : pa_rise) begin
					step = step + 4'sd1;
				end
				if (cfg_neg_r ? pb_fall : pb_rise) begin
					step = step - 4'sd1;
				end
			end
			`FORM_QUAD_X1: begin
				// one count per cycle on phase A active edge, B decides direction
				if (cfg_neg_r ? pa_fall : pa_rise) begin
					step = ((pb_lvl ^ cfg_neg_r) ? -4'sd1 : 4'sd1);
				end
			end
			`FORM_QUAD_X2: begin
				// both edges of phase A
				if (pa_rise | pa_fall) begin
					step = ((pa_lvl ^ pb_lvl) ? 4'sd1 : -4'sd1);
				end
			end
			`FORM_QUAD_X4: begin
				// every edge of both phases; A-led means forward
				if (pa_rise | pa_fall) begin
					step = ((pa_lvl ^ pb_lvl) ? 4'sd1 : -4'sd1);
				end
				if (pb_rise | pb_fall) begin
					step = step + ((pa_lvl ^ pb_lvl) ? -4'sd1 : 4'sd1);
				end
			end
			default: begin
				step = 4'sd0; // unused codes give no motion
			end
		endcase
		// edges seen before the pipeline has settled are not trusted
		if (!settle_done) begin
			step = 4'sd0;
		end
	end

	// feedback counts are same-clock strobes and need no synchroniser
	always @* begin
		fb = 4'sd0;
		if (feedback_up) begin
			fb = fb + 4'sd1;
		end
		if (feedback_down) begin
			fb = fb - 4'sd1;
		end
	end

	// level mode holds clear while the qualified clear is high; edge mode fires once
	always @* begin
		if (cfg_clrmode_r) begin
			clr_active = clr_fire;
		end else begin
			clr_active = (clr_st_r == ST_VALID) | clr_fire;
		end
	end

	// error counter: reference in, feedback out, clear overrides both
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			error_count <= `ERR_ZERO;
		end else if (clr_active) begin
			error_count <= `ERR_ZERO;
		end else begin
			error_count <= error_count + {{(`ERR_W-4){step[3]}}, step}
				- {{(`ERR_W-4){fb[3]}}, fb};
		end
	end

	// loop is prohibited while the qualified clear is high, in either mode
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			position_loop_en <= 1'b0;
			ref_step         <= 1'b0;
		end else begin
			position_loop_en <= ~((clr_st_r == ST_VALID) | clr_fire);
			ref_step         <= (step != 4'sd0) & ~clr_active;
		end
	end
endmodule // pulse_reference_decoder

// [verification/pulse_reference_decoder_asserts.sv]
// port checker for the reference pulse decoder
`timescale 1ns/1ps
module pulse_reference_decoder_asserts (
	input wire        sys_clk,             // clock
	input wire        sys_rst,             // reset
	input wire        reference_pulse_in,  // pin a
	input wire        reference_sign_in,   // pin b
	input wire        counter_clear_in,    // clear
	input wire [15:0] pulse_config_switch, // switch
	input wire        feedback_up,         // fb
	input wire        feedback_down,       // fb
	input wire [31:0] error_count,         // error
	input wire        position_loop_en,    // loop
	input wire        ref_step             // step
);
	reg  [7:0]  chg_r; // input activity, wide enough for sync delay
	reg  [3:0]  fb_r;  // recent feedback
	reg  [2:0]  in_r;  // last pins and logic bit
	reg  [10:0] hi_r;  // clear high run
	reg  [3:0]  lo_r;  // clear low run
	wire [2:0]  in_now = {reference_pulse_in, reference_sign_in, pulse_config_switch[13]};
	// run counters saturate so long holds never wrap
	always @(posedge sys_clk) begin
		in_r <= in_now;
		chg_r <= sys_rst ? 8'h00 : {chg_r[6:0], in_r != in_now};
		fb_r <= sys_rst ? 4'h0 : {fb_r[2:0], feedback_up | feedback_down};
		hi_r <= !counter_clear_in ? 11'h000 : hi_r + {10'h000, hi_r != 11'h7ff};
		lo_r <= (sys_rst | counter_clear_in) ? 4'h0 : lo_r + {3'h0, lo_r != 4'hf};
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_rst_zero: assert property ($fell(sys_rst) |-> error_count == 32'h0)
		else $error("count not cleared by reset");
	chk_step_cause: assert property (ref_step |-> chg_r != 8'h00)
		else $error("step without input activity");
	chk_step_single: assert property (ref_step |=> !ref_step)
		else $error("step pulse too long");
	chk_step_moves: assert property (
		ref_step && fb_r == 4'h0 |-> !$stable(error_count))
		else $error("step did not move count");
	chk_count_still: assert property (
		lo_r > 4'h3 && !ref_step && fb_r == 4'h0 |-> $stable(error_count))
		else $error("count moved without cause");
	chk_loop_off: assert property (hi_r > 11'h44b |-> !position_loop_en)
		else $error("loop enabled during clear");
	chk_held_zero: assert property (
		hi_r > 11'h44b && !pulse_config_switch[10] |-> error_count == 32'h0 && !ref_step)
		else $error("count moved during level clear");
	chk_loop_on: assert property (lo_r > 4'hb |-> position_loop_en)
		else $error("loop not enabled after clear");
endmodule // pulse_reference_decoder_asserts

// [verification/pulse_host_model.sv]
// host controller model issuing reference pulse trains
`timescale 1ns/1ps
module pulse_host_model (
	input  wire sys_clk, // clock
	output reg  pin_a,   // pulse, phase a, forward
	output reg  pin_b    // sign, phase b, reverse
);
	// 64 cycles a level keeps every form below its rated rate
	localparam int GAP = 64;
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// pins change just after an edge
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	// park both lines at the idle level of the logic sense
	task automatic idle(input bit neg);
		hold(1);
		pin_a = neg;
		pin_b = neg;
	endtask
	// one step (one quadrature cycle); dir high is positive
	task automatic step(input logic [2:0] form, input bit dir, input bit neg);
		hold(1);
		if (form == 3'h1) begin
			if (dir) pin_a = !neg;
			else pin_b = !neg;
		end else if (form > 3'h1) begin
			for (int i = 0; i < 3; i++) begin
				if (i[0] != dir) pin_a = !pin_a;
				else pin_b = !pin_b;
				hold(GAP);
			end
			if (dir) pin_b = !pin_b;
			else pin_a = !pin_a;
		end else begin
			pin_b = dir ^ neg;
			hold(GAP);
			pin_a = !neg;
		end
		hold(GAP);
		pin_a = neg;
		pin_b = neg;
		hold(GAP);
	endtask
endmodule // pulse_host_model

// [verification/testbench.sv]
// self-checking bench for the reference pulse decoder
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
	end \
end
module testbench;
	reg         sys_clk = 1'b0; // clock
	reg         sys_rst = 1'b1; // reset
	reg         clr = 1'b0;     // clear pin
	reg  [15:0] cfg = 16'h0000; // switch word
	reg         fb_up = 1'b0;   // feedback plus
	reg         fb_dn = 1'b0;   // feedback minus
	wire        pin_a;
	wire        pin_b;
	wire [31:0] error_count;
	wire        loop_en;
	wire        ref_step;
	int         bad_count = 0;
	int         checks = 0;
	reg  [31:0] base;
	int         steps_seen = 0; // ref_step pulses counted
	int         steps_base;
	reg  [7:0]  mag;
	// row: form[12:10], dir[9], negative logic[8], signed change[7:0]
	reg  [12:0] rows [0:11];
	always #10 sys_clk = ~sys_clk;
	// count step pulses at the falling edge, where the registered pulse is settled
	always @(negedge sys_clk) begin
		if (ref_step === 1'b1) steps_seen++;
	end
	pulse_host_model pulse_host_model_inst (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));
	pulse_reference_decoder pulse_reference_decoder_inst (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reference_pulse_in(pin_a), .reference_sign_in(pin_b),
		.counter_clear_in(clr), .pulse_config_switch(cfg), .feedback_up(fb_up),
		.feedback_down(fb_dn), .error_count(error_count), .position_loop_en(loop_en),
		.ref_step(ref_step));
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic stop_test;
		$display("TB: %0d checks, %0d mismatches", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// clear driven high and held for n cycles; it is left high on return
	task automatic hold_clear(input int n);
		clr = 1'b1;
		wait_n(n);
	endtask
	// a hang is cut short well past the expected run length
	initial begin
		#1000000;
		bad_count++;
		stop_test;
	end
	initial begin
		rows = '{13'h0201, 13'h00ff, 13'h0601, 13'h04ff, 13'h0a01, 13'h08ff,
			13'h0e02, 13'h0cfe, 13'h1204, 13'h10fc, 13'h1600, 13'h0301};
		wait_n(2);
		sys_rst = 1'b0;
		wait_n(4);
		`CHK("reset count", 32'h0, error_count);
		for (int r = 0; r < 12; r++) begin
			cfg = {2'b00, rows[r][8], 7'h00, rows[r][12:10], 3'h0};
			pulse_host_model_inst.idle(rows[r][8]);
			wait_n(8);
			base = error_count;
			steps_base = steps_seen;
			pulse_host_model_inst.step(rows[r][12:10], rows[r][9], rows[r][8]);
			wait_n(8);
			`CHK("row", base + {{24{rows[r][7]}}, rows[r][7:0]}, error_count);
			mag = rows[r][7] ? -rows[r][7:0] : rows[r][7:0];
			`CHK("row steps", {24'h000000, mag}, steps_seen - steps_base);
		end
		$display("TB: form table done");
		base = error_count;
		fb_up = 1'b1;
		wait_n(1);
		fb_up = 1'b0;
		wait_n(6);
		`CHK("feedback up", base - 32'h1, error_count);
		cfg = 16'h0020;
		pulse_host_model_inst.idle(1'b0);
		fb_dn = 1'b1;
		wait_n(1);
		fb_dn = 1'b0;
		pulse_host_model_inst.step(3'h4, 1'b1, 1'b0);
		hold_clear(1100);
		pulse_host_model_inst.step(3'h4, 1'b1, 1'b0);
		`CHK("level clear", 32'h0, error_count);
		`CHK("loop off", 1'b0, loop_en);
		clr = 1'b0;
		wait_n(16);
		`CHK("loop on", 1'b1, loop_en);
		$display("TB: level clear done");
		cfg = 16'h0420;
		pulse_host_model_inst.step(3'h4, 1'b1, 1'b0);
		hold_clear(1100);
		`CHK("edge clear", 32'h0, error_count);
		pulse_host_model_inst.step(3'h4, 1'b1, 1'b0);
		`CHK("count after edge", 32'h4, error_count);
		clr = 1'b0;
		wait_n(8);
		hold_clear(200);
		clr = 1'b0;
		wait_n(8);
		`CHK("short clear", 32'h4, error_count);
		$display("TB: edge clear done");
		// reset in mid-run with both pins idling high in negative logic
		cfg = 16'h2000;
		pulse_host_model_inst.idle(1'b1);
		wait_n(8);
		`CHK("idle high", 32'h4, error_count);
		sys_rst = 1'b1;
		wait_n(2);
		`CHK("reset clears", 32'h0, error_count);
		`CHK("reset loop", 1'b0, loop_en);
		`CHK("reset step", 1'b0, ref_step);
		sys_rst = 1'b0;
		wait_n(1);
		`CHK("loop after reset", 1'b1, loop_en);
		wait_n(8);
		`CHK("no false edge", 32'h0, error_count);
		pulse_host_model_inst.step(3'h0, 1'b1, 1'b1);
		wait_n(8);
		`CHK("step after reset", 32'h1, error_count);
		$display("TB: mid-run reset done");
		stop_test;
	end
endmodule // testbench
bind pulse_reference_decoder pulse_reference_decoder_asserts pulse_reference_decoder_asserts_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reference_pulse_in(reference_pulse_in),
	.reference_sign_in(reference_sign_in), .counter_clear_in(counter_clear_in),
	.pulse_config_switch(pulse_config_switch), .feedback_up(feedback_up),
	.feedback_down(feedback_down), .error_count(error_count),
	.position_loop_en(position_loop_en), .ref_step(ref_step));
